// [rtl/uhds_scheduler.sv]
// Descriptor scheduler with shared descriptor memory and Avalon-MM slave.
`timescale 1ns/1ns
// How it works
// - Sixteen descriptors in each of three lists.
// - Async list bulk/control, others interrupt, isochronous.
// - Run isochronous, then interrupt, then async list.
// - Pure bus slave, works from shared memory.
// - Each active descriptor moves data as channel.
// - Completion interrupts grouped by AND/OR masks.
// - Done bit set when descriptor completes.
// - Four interrupts: three lists and start-of-frame.
// - Interrupt latency counted in 125 us microframes.
// - Four-word descriptor, status flags in DW3.
// - Descriptor field widths as documented.
// - Job-pending set by software, cleared on end.
// - Babble sets overrun, clears pending and in-use.
// - PID error retried thrice, then error flag.
// - Sixteen-bit grouping masks reset to zero.
module uhds_scheduler
  import uhds_pkg::*;
#(
  parameter int UFRAME_CYCLES = UFRAME_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             xfer_req,
  output logic      [1:0]  xfer_list,
  output logic      [6:0]  xfer_device,
  output logic      [3:0]  xfer_endpoint,
  output logic      [1:0]  xfer_token,
  output logic      [10:0] xfer_max_packet,
  output logic      [14:0] xfer_length,
  output logic      [15:0] xfer_buf_ptr,
  output logic             xfer_toggle,
  output logic             xfer_ping,
  input  wire logic        xfer_ack,
  input  wire logic        xfer_babble,
  input  wire logic        xfer_pid_err,
  input  wire logic        xfer_nak,
  input  wire logic [14:0] xfer_count,
  output logic             irq_iso,
  output logic             irq_int,
  output logic             irq_atl,
  output logic             irq_sof
);
  if (UFRAME_CYCLES < 2) begin : g_bad_uframe
    $error("UFRAME_CYCLES must be at least 2.");
  end

  localparam int FW = $clog2(UFRAME_CYCLES);

  typedef enum {ST_IDLE, ST_SCAN, ST_ISSUE, ST_WAIT, ST_BACK} uhds_state_t;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction : merge

  function automatic logic [7:0] midx(input logic [1:0] l, input logic [3:0] d, input logic [1:0] w);
    return {l, d, w};
  endfunction : midx

  logic [31:0]      mem [MEM_WORDS];
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rd_data;
  logic             req;
  logic             wr_go;
  logic             mem_hit;
  logic             mem_wr;
  logic [1:0]       cpu_list;
  logic [3:0]       cpu_desc;
  logic [2:0]       cpu_dw;
  logic [1:0]       ctrl_reg;
  logic [LAT_W-1:0] lat_reg;
  logic [LAT_W-1:0] lat_cnt_reg;
  logic [15:0]      done_reg [NUM_LISTS];
  logic [15:0]      or_reg [NUM_LISTS];
  logic [15:0]      and_reg [NUM_LISTS];
  logic [2:0]       hit;
  logic [FW-1:0]    tick_reg;
  logic [15:0]      frame_reg;
  logic             sof;
  uhds_state_t      st_reg;
  logic [1:0]       list_reg;
  logic [3:0]       desc_reg;
  logic [1:0]       retry_reg;
  logic [31:0]      wb0_reg;
  logic [31:0]      wb3_reg;
  logic             wb_done_reg;
  logic [31:0]      dw0;
  logic [31:0]      dw1;
  logic [31:0]      dw2;
  logic [31:0]      dw3;
  logic             last_desc;

  // Avalon slave: one wait cycle, then the answer.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_go           = avs_write & ack_reg;
  assign avs_readdata    = rdata_reg;
  assign cpu_list        = avs_address[10:9];
  assign cpu_desc        = avs_address[8:5];
  assign cpu_dw          = avs_address[4:2];
  assign mem_hit         = avs_address < MEM_TOP;
  assign mem_wr          = wr_go & mem_hit & ~cpu_dw[2];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg) rdata_reg <= rd_data;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    if (mem_hit) begin
      if (!cpu_dw[2]) rd_data = mem[midx(cpu_list, cpu_desc, cpu_dw[1:0])];
    end else if (avs_address == REG_CTRL) begin
      rd_data = {30'h0, ctrl_reg};
    end else if (avs_address == REG_LAT) begin
      rd_data = {{(32-LAT_W){1'b0}}, lat_reg};
    end else if (avs_address == REG_FRAME) begin
      rd_data = {16'h0, frame_reg};
    end
    for (int l = 0; l < NUM_LISTS; l++) begin
      if (avs_address == REG_DONE + 12'(4*l)) rd_data = {16'h0, done_reg[l]};
      if (avs_address == REG_OR + 12'(4*l)) rd_data = {16'h0, or_reg[l]};
      if (avs_address == REG_AND + 12'(4*l)) rd_data = {16'h0, and_reg[l]};
    end
  end

  // Descriptor memory; the bus write wins and stalls write-back.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_WORDS; i++) mem[i] <= 32'h0;
    end else if (mem_wr) begin
      mem[midx(cpu_list, cpu_desc, cpu_dw[1:0])] <= merge(mem[midx(cpu_list, cpu_desc, cpu_dw[1:0])],
                                                          avs_writedata, avs_byteenable);
    end else if (st_reg == ST_BACK) begin
      mem[midx(list_reg, desc_reg, 2'h0)] <= wb0_reg;
      mem[midx(list_reg, desc_reg, 2'h3)] <= wb3_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 2'h0;
      lat_reg  <= '0;
    end else if (wr_go) begin
      if (avs_address == REG_CTRL) ctrl_reg <= avs_writedata[1:0];
      if (avs_address == REG_LAT) lat_reg <= avs_writedata[LAT_W-1:0];
    end
  end

  // Grouping masks.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int l = 0; l < NUM_LISTS; l++) begin
        or_reg[l]  <= 16'h0000;
        and_reg[l] <= 16'h0000;
      end
    end else if (wr_go) begin
      for (int l = 0; l < NUM_LISTS; l++) begin
        if (avs_address == REG_OR + 12'(4*l)) or_reg[l] <= avs_writedata[15:0];
        if (avs_address == REG_AND + 12'(4*l)) and_reg[l] <= avs_writedata[15:0];
      end
    end
  end

  // Done maps: write one to clear, a new completion wins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int l = 0; l < NUM_LISTS; l++) done_reg[l] <= 16'h0;
    end else begin
      for (int l = 0; l < NUM_LISTS; l++) begin
        for (int d = 0; d < N_DESC; d++) begin
          if (st_reg == ST_BACK && !mem_wr && wb_done_reg && list_reg == 2'(l) && desc_reg == 4'(d)) begin
            done_reg[l][d] <= 1'b1;
          end else if (wr_go && avs_address == REG_DONE + 12'(4*l) && avs_writedata[d]) begin
            done_reg[l][d] <= 1'b0;
          end
        end
      end
    end
  end

  // Microframe timer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_reg  <= '0;
      frame_reg <= 16'h0;
    end else if (sof) begin
      tick_reg  <= '0;
      frame_reg <= frame_reg + 16'h1;
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end
  assign sof = tick_reg == FW'(UFRAME_CYCLES - 1);

  // Group conditions per list.
  generate
    for (genvar g = 0; g < NUM_LISTS; g++) begin : g_hit
      assign hit[g] = (|(done_reg[g] & or_reg[g])) |
                      ((|and_reg[g]) && ((done_reg[g] & and_reg[g]) == and_reg[g]));
    end
  endgenerate

  // Latency counts microframes while any group is satisfied.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lat_cnt_reg <= '0;
    end else if (hit == 3'h0) begin
      lat_cnt_reg <= '0;
    end else if (sof && lat_cnt_reg != lat_reg) begin
      lat_cnt_reg <= lat_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_iso <= 1'b0;
      irq_int <= 1'b0;
      irq_atl <= 1'b0;
      irq_sof <= 1'b0;
    end else begin
      irq_iso <= hit[LIST_ISO] && lat_cnt_reg >= lat_reg;
      irq_int <= hit[LIST_INT] && lat_cnt_reg >= lat_reg;
      irq_atl <= hit[LIST_ATL] && lat_cnt_reg >= lat_reg;
      irq_sof <= sof && ctrl_reg[CTRL_SOF_IRQ];
    end
  end

  assign dw0       = mem[midx(list_reg, desc_reg, 2'h0)];
  assign dw1       = mem[midx(list_reg, desc_reg, 2'h1)];
  assign dw2       = mem[midx(list_reg, desc_reg, 2'h2)];
  assign dw3       = mem[midx(list_reg, desc_reg, 2'h3)];
  assign last_desc = desc_reg == DESC_LAST;

  // Scheduler walking the three lists once per microframe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg      <= ST_IDLE;
      list_reg    <= LIST_ISO;
      desc_reg    <= 4'h0;
      retry_reg   <= 2'h0;
      wb0_reg     <= 32'h0;
      wb3_reg     <= 32'h0;
      wb_done_reg <= 1'b0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (sof && ctrl_reg[CTRL_SCHED]) begin
            st_reg   <= ST_SCAN;
            list_reg <= LIST_ISO;
            desc_reg <= 4'h0;
          end
        end
        ST_SCAN: begin
          if (dw3[A_BIT] && dw0[V_BIT]) begin
            st_reg    <= ST_ISSUE;
            retry_reg <= 2'h0;
          end else if (!last_desc) begin
            desc_reg <= desc_reg + 4'h1;
          end else if (list_reg == LIST_ATL) begin
            st_reg <= ST_IDLE;
          end else begin
            list_reg <= list_reg + 2'h1;
            desc_reg <= 4'h0;
          end
        end
        ST_ISSUE: st_reg <= ST_WAIT;
        ST_WAIT: begin
          if (xfer_ack) begin
            wb0_reg     <= dw0;
            wb3_reg     <= dw3;
            wb_done_reg <= 1'b1;
            st_reg      <= ST_BACK;
            if (xfer_babble) begin
              wb3_reg[B_BIT] <= 1'b1;
              wb3_reg[A_BIT] <= 1'b0;
              wb0_reg[V_BIT] <= 1'b0;
            end else if (xfer_pid_err && retry_reg != PID_RETRIES) begin
              retry_reg <= retry_reg + 2'h1;
              st_reg    <= ST_ISSUE;
            end else if (xfer_pid_err) begin
              wb3_reg[X_BIT] <= 1'b1;
              wb3_reg[A_BIT] <= 1'b0;
              wb0_reg[V_BIT] <= 1'b0;
            end else if (xfer_nak && dw3[NAK_LSB +: 4] != 4'h0) begin
              wb3_reg[NAK_LSB +: 4] <= dw3[NAK_LSB +: 4] - 4'h1;
              wb_done_reg           <= 1'b0;
            end else if (xfer_nak) begin
              wb3_reg[H_BIT] <= 1'b1;
              wb3_reg[A_BIT] <= 1'b0;
            end else begin
              wb3_reg[DONE_CNT_LSB +: 15] <= xfer_count;
              wb3_reg[DT_BIT]             <= ~dw3[DT_BIT];
              wb3_reg[A_BIT]              <= 1'b0;
            end
          end
        end
        ST_BACK: begin
          if (!mem_wr) st_reg <= ST_SCAN;
          if (!mem_wr && last_desc && list_reg == LIST_ATL) st_reg <= ST_IDLE;
          if (!mem_wr && last_desc && list_reg != LIST_ATL) begin
            list_reg <= list_reg + 2'h1;
            desc_reg <= 4'h0;
          end else if (!mem_wr && !last_desc) begin
            desc_reg <= desc_reg + 4'h1;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Transfer request toward the link; held until acknowledged.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_req        <= 1'b0;
      xfer_list       <= LIST_ISO;
      xfer_device     <= 7'h0;
      xfer_endpoint   <= 4'h0;
      xfer_token      <= 2'h0;
      xfer_max_packet <= 11'h0;
      xfer_length     <= 15'h0;
      xfer_buf_ptr    <= 16'h0;
      xfer_toggle     <= 1'b0;
      xfer_ping       <= 1'b0;
    end else if (st_reg == ST_ISSUE) begin
      xfer_req        <= 1'b1;
      xfer_list       <= list_reg;
      xfer_device     <= dw1[DEV_LSB +: 7];
      xfer_endpoint   <= dw1[EP_LSB +: 4];
      xfer_token      <= dw1[TOK_LSB +: 2];
      xfer_max_packet <= dw0[MPS_LSB +: 11];
      xfer_length     <= dw0[REQ_LSB +: 15];
      xfer_buf_ptr    <= dw2[BUF_LSB +: 16];
      xfer_toggle     <= dw3[DT_BIT];
      xfer_ping       <= dw3[P_BIT];
    end else if (xfer_ack) begin
      xfer_req <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_LIST_ORDER: assert property (st_reg == ST_SCAN && $past(st_reg) != ST_IDLE && $changed(list_reg) |->
    list_reg == $past(list_reg) + 2'h1) else $error("List order broken.");
  AST_LIST_RANGE: assert property (xfer_req |-> xfer_list != 2'h3) else $error("Bad list.");
  AST_BUS_ANSWER: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Slave answer late.");
  AST_BABBLE: assert property (st_reg == ST_WAIT && xfer_ack && xfer_babble |=>
    wb3_reg[B_BIT] && !wb3_reg[A_BIT] && !wb0_reg[V_BIT]) else $error("Babble flags wrong.");
  AST_PID_RETRY: assert property (st_reg == ST_WAIT && xfer_ack && xfer_pid_err && !xfer_babble &&
    retry_reg != PID_RETRIES |=> st_reg == ST_ISSUE ##1 xfer_req) else $error("No retry.");
  AST_PID_FAIL: assert property (st_reg == ST_WAIT && xfer_ack && xfer_pid_err && !xfer_babble &&
    retry_reg == PID_RETRIES |=> wb3_reg[X_BIT] && !wb3_reg[A_BIT]) else $error("Error flag missing.");
  AST_JOB_END: assert property (st_reg == ST_WAIT && xfer_ack && !xfer_babble && !xfer_pid_err &&
    !xfer_nak |=> !wb3_reg[A_BIT] && st_reg == ST_BACK) else $error("Job flag kept.");
  AST_DONE_SET: assert property (st_reg == ST_BACK && !mem_wr && wb_done_reg |=>
    done_reg[$past(list_reg)][$past(desc_reg)]) else $error("Done bit not set.");
  AST_OR_IRQ: assert property (lat_reg == '0 && (|(done_reg[0] & or_reg[0])) |=> irq_iso)
    else $error("OR group missed.");
  AST_IRQ_CAUSE: assert property ($rose(irq_atl) |-> $past(hit[2]) && $past(lat_cnt_reg >= lat_reg))
    else $error("Spurious interrupt.");
  AST_SOF_IRQ: assert property (sof && ctrl_reg[CTRL_SOF_IRQ] |=> irq_sof ##1 !irq_sof)
    else $error("Frame interrupt wrong.");

  COV_BABBLE: cover property (st_reg == ST_WAIT && xfer_ack && xfer_babble);
  COV_PID_FAIL: cover property (st_reg == ST_WAIT && xfer_ack && xfer_pid_err && retry_reg == PID_RETRIES);
  COV_AND_IRQ: cover property (irq_int && and_reg[LIST_INT] != 16'h0);
  COV_FULL_WALK: cover property (st_reg == ST_SCAN && list_reg == LIST_ATL && last_desc ##1 st_reg == ST_IDLE);
endmodule : uhds_scheduler

// [pkg/uhds_pkg.sv]
// Constants shared by the descriptor scheduler.
package uhds_pkg;
  localparam int          NUM_LISTS     = 3;
  localparam int          N_DESC        = 16;
  localparam logic [1:0]  LIST_ISO      = 2'h0;
  localparam logic [1:0]  LIST_INT      = 2'h1;
  localparam logic [1:0]  LIST_ATL      = 2'h2;
  localparam logic [3:0]  DESC_LAST     = 4'hf;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          UFRAME_NS     = 125000;
  localparam int          UFRAME_CYC    = UFRAME_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  PID_RETRIES   = 2'h3;
  localparam int          LAT_W         = 8;
  localparam int          MEM_WORDS     = NUM_LISTS * N_DESC * 4;
  localparam int          A_BIT         = 31;
  localparam int          H_BIT         = 30;
  localparam int          B_BIT         = 29;
  localparam int          X_BIT         = 28;
  localparam int          P_BIT         = 26;
  localparam int          DT_BIT        = 25;
  localparam int          NAK_LSB       = 19;
  localparam int          DONE_CNT_LSB  = 0;
  localparam int          V_BIT         = 0;
  localparam int          REQ_LSB       = 3;
  localparam int          MPS_LSB       = 18;
  localparam int          EP_LSB        = 0;
  localparam int          DEV_LSB       = 4;
  localparam int          TOK_LSB       = 11;
  localparam int          BUF_LSB       = 8;
  localparam int          RL_LSB        = 25;
  localparam int          CTRL_SCHED    = 0;
  localparam int          CTRL_SOF_IRQ  = 1;
  localparam logic [11:0] MEM_TOP       = 12'h600;
  localparam logic [11:0] REG_CTRL      = 12'h600;
  localparam logic [11:0] REG_LAT       = 12'h604;
  localparam logic [11:0] REG_FRAME     = 12'h608;
  localparam logic [11:0] REG_DONE      = 12'h610;
  localparam logic [11:0] REG_OR        = 12'h620;
  localparam logic [11:0] REG_AND       = 12'h630;
endpackage : uhds_pkg

// [dv/uhds_usb_model.sv]
// Model of the attached USB device that answers the scheduler's transfer requests.
`timescale 1ns/1ns
module uhds_usb_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        xfer_req,
  input  wire logic [14:0] xfer_length,
  input  wire logic [1:0]  fault_mode,
  output logic             xfer_ack,
  output logic             xfer_babble,
  output logic             xfer_pid_err,
  output logic             xfer_nak,
  output logic      [14:0] xfer_count
);
  logic [2:0] wait_reg;
  logic       busy_reg;

  // Status lines carry a changing pattern outside the ack cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_reg     <= 3'h0;
      busy_reg     <= 1'b0;
      xfer_ack     <= 1'b0;
      xfer_babble  <= 1'b0;
      xfer_pid_err <= 1'b0;
      xfer_nak     <= 1'b0;
      xfer_count   <= 15'h0;
    end else begin
      xfer_ack     <= 1'b0;
      xfer_babble  <= ~xfer_babble;
      xfer_pid_err <= ~xfer_pid_err;
      xfer_nak     <= ~xfer_nak;
      xfer_count   <= ~xfer_count;
      if (busy_reg) begin
        busy_reg <= xfer_req;
      end else if (xfer_req) begin
        if (wait_reg == 3'h0) begin
          xfer_ack     <= 1'b1;
          busy_reg     <= 1'b1;
          wait_reg     <= 3'($urandom_range(4, 0));
          xfer_count   <= xfer_length;
          xfer_babble  <= (fault_mode == 2'h1);
          xfer_pid_err <= (fault_mode == 2'h2);
          xfer_nak     <= (fault_mode == 2'h3);
        end else begin
          wait_reg <= wait_reg - 3'h1;
        end
      end
    end
  end
endmodule : uhds_usb_model

// [dv/uhds_scheduler_bench.sv]
// Self-checking bench for the descriptor scheduler.
`timescale 1ns/1ns
module uhds_scheduler_bench;
  import uhds_pkg::*;
  localparam int UF = 50;
  logic        core_clk = 1'b0;
  logic        rst;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        xfer_req;
  logic [1:0]  xfer_list;
  logic [6:0]  xfer_device;
  logic [3:0]  xfer_endpoint;
  logic [1:0]  xfer_token;
  logic [10:0] xfer_max_packet;
  logic [14:0] xfer_length;
  logic [15:0] xfer_buf_ptr;
  logic        xfer_toggle;
  logic        xfer_ping;
  logic        xfer_ack;
  logic        xfer_babble;
  logic        xfer_pid_err;
  logic        xfer_nak;
  logic [14:0] xfer_count;
  logic        irq_iso;
  logic        irq_int;
  logic        irq_atl;
  logic        irq_sof;
  logic [1:0]  fault_mode;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0]  list_q[$];
  logic [6:0]  e_dev;
  logic [3:0]  e_ep;
  logic [10:0] e_mps;
  logic [14:0] e_len;
  logic [15:0] e_buf;
  logic [15:0] r16;
  logic [56:0] e_fld [4];
  logic        req_d = 1'b0;
  int          num_errors = 0;
  int          total_checks = 0;
  int          req_cnt = 0;
  int          sof_cnt = 0;
  int          cyc = 0;
  int          k;
  int          c;

  uhds_scheduler #(.UFRAME_CYCLES(UF)) uhds_scheduler_inst (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .xfer_req(xfer_req), .xfer_list(xfer_list), .xfer_device(xfer_device), .xfer_endpoint(xfer_endpoint),
    .xfer_token(xfer_token), .xfer_max_packet(xfer_max_packet), .xfer_length(xfer_length),
    .xfer_buf_ptr(xfer_buf_ptr), .xfer_toggle(xfer_toggle), .xfer_ping(xfer_ping), .xfer_ack(xfer_ack),
    .xfer_babble(xfer_babble), .xfer_pid_err(xfer_pid_err), .xfer_nak(xfer_nak), .xfer_count(xfer_count),
    .irq_iso(irq_iso), .irq_int(irq_int), .irq_atl(irq_atl), .irq_sof(irq_sof));

  uhds_usb_model uhds_usb_model_inst (.core_clk(core_clk), .rst(rst), .xfer_req(xfer_req),
    .xfer_length(xfer_length), .fault_mode(fault_mode), .xfer_ack(xfer_ack), .xfer_babble(xfer_babble),
    .xfer_pid_err(xfer_pid_err), .xfer_nak(xfer_nak), .xfer_count(xfer_count));

  always #4 core_clk = ~core_clk;

  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic wr);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 32'h0, 1'b0);
  endtask : rd

  // Software builds one descriptor and hands it over by setting the active flag last.
  task automatic setup(input logic [1:0] l, input logic [3:0] n);
    logic [11:0] b;
    logic [1:0]  tok;
    logic        png;
    b = {1'b0, l, n, 5'h0};
    tok = 2'($urandom);
    png = 1'($urandom);
    e_dev = 7'($urandom);
    e_ep = 4'($urandom);
    e_mps = 11'($urandom);
    e_len = 15'($urandom_range(2047, 1));
    e_buf = 16'($urandom);
    e_fld[l] = {e_dev, e_ep, e_mps, e_len, e_buf, tok, png, 1'b0};
    bus(b, {1'b0, 2'h1, e_mps, e_len, 2'h0, 1'b1}, 1'b1);
    bus(b + 12'h4, {19'h0, tok, e_dev, e_ep}, 1'b1);
    bus(b + 12'h8, {3'h0, 4'h3, 1'b0, e_buf, 8'h0}, 1'b1);
    bus(b + 12'hc, {1'b1, 4'h0, png, 26'h0}, 1'b1);
  endtask : setup

  task automatic wait_req(input int n);
    for (int i = 0; i < 2000 && req_cnt < n; i++) @(posedge core_clk);
    total_checks++;
    if (req_cnt < n) fail("request missing");
  endtask : wait_req

  task automatic wait_hi(ref logic s, input int n);
    for (c = 0; c < n && s !== 1'b1; c++) @(posedge core_clk);
    total_checks++;
    if (s !== 1'b1) fail("interrupt missing");
  endtask : wait_hi

  // Watches reads, requests and start-of-frame pulses.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      report_and_stop();
    end
    if (irq_sof === 1'b1) sof_cnt++;
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() != 0) begin
      total_checks++;
      if (((avs_readdata ^ exp_q[0]) & msk_q[0]) !== 32'h0) fail("read data");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (xfer_req === 1'b1 && !req_d) begin
      req_cnt++;
      list_q.push_back(xfer_list);
      total_checks++;
      if ({xfer_device, xfer_endpoint, xfer_max_packet, xfer_length, xfer_buf_ptr, xfer_token, xfer_ping,
           xfer_toggle} !== e_fld[xfer_list]) fail("fields");
    end
    req_d = xfer_req;
  end

  initial begin
    rst = 1'b1;
    avs_address = 12'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    fault_mode = 2'h0;
    void'($urandom(32'hb8f5));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int l = 0; l < 3; l++) begin
      rd(REG_OR + 12'(4 * l), 32'h0, 32'hffff_ffff);
      rd(REG_AND + 12'(4 * l), 32'h0, 32'hffff_ffff);
      rd(REG_DONE + 12'(4 * l), 32'h0, 32'hffff_ffff);
      r16 = 16'($urandom);
      bus(REG_AND + 12'(4 * l), {16'h0, r16}, 1'b1);
      rd(REG_AND + 12'(4 * l), {16'h0, r16}, 32'h0000_ffff);
      bus(REG_AND + 12'(4 * l), 32'h0, 1'b1);
    end
    bus(12'h010, $urandom, 1'b1);
    rd(12'h010, 32'h0, 32'hffff_ffff);
    rd(12'h640, 32'h0, 32'hffff_ffff);
    bus(12'h1e4, 32'hffff_ffff, 1'b1);
    avs_byteenable <= 4'h2;
    bus(12'h1e4, 32'h0, 1'b1);
    avs_byteenable <= 4'hf;
    rd(12'h1e4, 32'hffff_00ff, 32'hffff_ffff);
    $display("test registers done");
    setup(LIST_ISO, 4'h3);
    setup(LIST_INT, 4'h3);
    setup(LIST_ATL, 4'h3);
    bus(REG_OR, 32'h8, 1'b1);
    bus(REG_OR + 12'h8, 32'h8, 1'b1);
    bus(REG_CTRL, 32'h1, 1'b1);
    wait_req(3);
    total_checks++;
    if (list_q.size() != 3 ||
        {list_q[0], list_q[1], list_q[2]} !== {LIST_ISO, LIST_INT, LIST_ATL}) fail("order");
    wait_hi(irq_iso, 4 * UF);
    wait_hi(irq_atl, 4 * UF);
    rd(REG_DONE + 12'h8, 32'h8, 32'hffff_ffff);
    rd(12'h46c, 32'h0200_0000 | e_len, 32'h8200_7fff);
    bus(REG_OR + 12'h8, 32'h0, 1'b1);
    bus(REG_OR, 32'h0, 1'b1);
    $display("test order done");
    fault_mode <= 2'h1;
    k = req_cnt;
    setup(LIST_ATL, 4'h5);
    wait_req(k + 1);
    repeat (8) @(posedge core_clk);
    rd(12'h4ac, 32'h2000_0000, 32'ha000_0000);
    rd(12'h4a0, 32'h0, 32'h1);
    $display("test babble done");
    fault_mode <= 2'h2;
    k = req_cnt;
    setup(LIST_ATL, 4'h6);
    repeat (3 * UF) @(posedge core_clk);
    total_checks++;
    if (req_cnt != k + 4) fail("retry count");
    rd(12'h4cc, 32'h1000_0000, 32'h9000_0000);
    rd(12'h4c0, 32'h0, 32'h1);
    $display("test pid error done");
    fault_mode <= 2'h3;
    k = req_cnt;
    setup(LIST_ATL, 4'h7);
    wait_req(k + 1);
    repeat (8) @(posedge core_clk);
    rd(12'h4ec, 32'h4000_0000, 32'hc000_0000);
    $display("test nak done");
    fault_mode <= 2'h0;
    bus(REG_AND + 12'h4, 32'h3, 1'b1);
    setup(LIST_INT, 4'h0);
    repeat (3 * UF) @(posedge core_clk);
    total_checks++;
    if (irq_int !== 1'b0) fail("and group early");
    setup(LIST_INT, 4'h1);
    wait_hi(irq_int, 4 * UF);
    bus(REG_AND + 12'h4, 32'h0, 1'b1);
    bus(REG_DONE + 12'h4, 32'hffff, 1'b1);
    $display("test and group done");
    bus(REG_LAT, 32'h2, 1'b1);
    bus(REG_OR + 12'h4, 32'h4, 1'b1);
    bus(REG_CTRL, 32'h3, 1'b1);
    k = req_cnt;
    setup(LIST_INT, 4'h2);
    wait_req(k + 1);
    wait_hi(irq_int, 6 * UF);
    total_checks++;
    if (c < UF || c > 2 * UF + 10) fail("latency");
    sof_cnt = 0;
    repeat (10 * UF) @(posedge core_clk);
    total_checks++;
    if (sof_cnt < 9 || sof_cnt > 11) fail("sof count");
    $display("test latency done");
    report_and_stop();
  end
endmodule : uhds_scheduler_bench
